//--- logic/acg_regs.svh
// register map, field positions and reset values of the audio serial clock generator
//
// Contract
// - functional logic on the peripheral clock; auxiliary clock only feeds the dividers
// - an external clock on the high-clock pin may replace the auxiliary clock
// - internal mode: auxiliary clock through two cascaded dividers, high clock then bit clock
// - direction word 0x1C000000: transmit frame sync, high and bit clock pins driven
// - high-clock control bit 15 set: auxiliary clock divided by bits 0-11
// - bit-clock control bit 5 set: high clock divided by bits 0-4
// - a pin set as input is never driven, even while clocks run internally
// - direction word zero: transmit frame sync and bit clock taken from pins
// - bit clock from its pin: bit-clock divider has no effect
// - direction word 0x14000000: transmit high clock input, frame sync and bit clock driven
// - high-clock control bit 15 clear: high-clock pin divided by bits 0-11
// - with external high clock the port makes bit clock and frame sync itself
// - transmit and receive each own bit, high clock and failure-check settings
// - a power-down control decides behaviour while emulation halts
// - port can be clock master while its clock pins stay undriven
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH

`define ACG_ADDR_PDIR      8'h00
`define ACG_ADDR_TX_HC     8'h04
`define ACG_ADDR_TX_BC     8'h08
`define ACG_ADDR_TX_CK     8'h0c
`define ACG_ADDR_RX_HC     8'h10
`define ACG_ADDR_RX_BC     8'h14
`define ACG_ADDR_RX_CK     8'h18
`define ACG_ADDR_EMU       8'h1c
`define ACG_ADDR_STATUS    8'h20
`define ACG_ADDR_MASK      8'h24
`define ACG_ADDR_STATE     8'h28
`define ACG_SEC_STRIDE     8'h0c

`define ACG_PDIR_MASK      32'hfc00_0000
`define ACG_HC_MASK        32'h0000_8fff
`define ACG_BC_MASK        32'h0000_003f
`define ACG_CK_MASK        32'h0000_01ff
`define ACG_EMU_MASK       32'h0000_0001
`define ACG_IRQ_MASK       32'h0000_0003
`define ACG_RST_ZERO       32'h0000_0000

`define ACG_PDIR_BC_BIT    26
`define ACG_PDIR_HC_BIT    27
`define ACG_PDIR_FS_BIT    28
`define ACG_PDIR_STRIDE    3
`define ACG_PDIR_MASTER    32'h1c00_0000
`define ACG_PDIR_EXT_HC    32'h1400_0000
`define ACG_PDIR_ALL_IN    32'h0000_0000

`define ACG_HC_INT_BIT     15
`define ACG_HC_DIV_W       12
`define ACG_BC_INT_BIT     5
`define ACG_BC_DIV_W       5
`define ACG_CK_EN_BIT      8
`define ACG_CK_LIM_W       8
`define ACG_EMU_FREE_BIT   0

`define ACG_RESP_OKAY      2'h0
`define ACG_RESP_SLVERR    2'h2

`endif

//--- logic/acg_pkg.sv
// types shared by the audio serial clock generator
package acg_pkg;
	typedef logic [1:0]  acg_resp_t;
	typedef logic [31:0] acg_word_t;
endpackage

//--- logic/acg_divider.sv
// one programmable clock divider stage, divides source edges by divisor plus one
`timescale 1ns/100ps
module acg_divider #(
	parameter int W = 12
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         run,
	input  wire logic         src_tick,
	input  wire logic         src_level,
	input  wire logic [W-1:0] divisor,
	output logic              out_tick,
	output logic              out_level
);
	logic [W-1:0] count;
	wire          wrap = (count >= divisor);
	wire          pass = (divisor == '0);

	if (W < 1) begin : g_bad_width
		$error("acg_divider width must be at least one");
	end

	// wrap on >= so a divisor lowered mid-count cannot strand the counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count     <= '0;
			out_tick  <= 1'b0;
			out_level <= 1'b0;
		end else begin
			out_tick <= run && src_tick && wrap;
			if (run && src_tick) begin
				count <= wrap ? '0 : count + 1'b1;
			end
			// a halt must freeze the pass-through level as well as the counter
			if (run) begin
				out_level <= pass ? src_level : (count <= (divisor >> 1));
			end
		end
	end
endmodule

//--- logic/acg_clock_gen.sv
// audio serial clock generator: dividers, pin directions, failure check, axi4-lite registers
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "acg_regs.svh"
module acg_clock_gen #(
	parameter int ADDR_W     = 8,
	parameter int FRAME_BITS = 32
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              aux_clock_in,
	input  wire logic              emu_halt,
	input  wire logic              tx_frame_sync_pin_in,
	output logic                   tx_frame_sync_pin_out,
	output logic                   tx_frame_sync_pin_oe,
	input  wire logic              tx_high_clock_pin_in,
	output logic                   tx_high_clock_pin_out,
	output logic                   tx_high_clock_pin_oe,
	input  wire logic              tx_bit_clock_pin_in,
	output logic                   tx_bit_clock_pin_out,
	output logic                   tx_bit_clock_pin_oe,
	input  wire logic              rx_frame_sync_pin_in,
	output logic                   rx_frame_sync_pin_out,
	output logic                   rx_frame_sync_pin_oe,
	input  wire logic              rx_high_clock_pin_in,
	output logic                   rx_high_clock_pin_out,
	output logic                   rx_high_clock_pin_oe,
	input  wire logic              rx_bit_clock_pin_in,
	output logic                   rx_bit_clock_pin_out,
	output logic                   rx_bit_clock_pin_oe,
	output logic                   tx_serial_clock,
	output logic                   tx_frame_sync,
	output logic                   rx_serial_clock,
	output logic                   rx_frame_sync,
	output logic                   irq,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output acg_pkg::acg_resp_t     s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output acg_pkg::acg_word_t     s_axi_rdata,
	output acg_pkg::acg_resp_t     s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	import acg_pkg::*;

	if (ADDR_W < 6 || ADDR_W > 8 || FRAME_BITS < 2 || FRAME_BITS > 256) begin : g_bad_param
		$error("acg_clock_gen parameters out of range");
	end

	// registers
	acg_word_t   pdir;
	acg_word_t   hc_ctl [2];
	acg_word_t   bc_ctl [2];
	acg_word_t   ck_ctl [2];
	acg_word_t   emu_ctl;
	acg_word_t   status;
	acg_word_t   mask;

	// bus holding state
	logic [ADDR_W-1:0] aw_addr;
	acg_word_t         w_data;
	logic [3:0]        w_strb;

	// synchronisers: aux clock and the six pins are foreign to the peripheral clock
	logic [6:0]  sync1;
	logic [6:0]  sync2;
	logic [6:0]  sync3;
	wire  [6:0]  raw_in = {rx_frame_sync_pin_in, rx_high_clock_pin_in, rx_bit_clock_pin_in,
	                       tx_frame_sync_pin_in, tx_high_clock_pin_in, tx_bit_clock_pin_in,
	                       aux_clock_in};
	wire  [6:0]  rise   = sync2 & ~sync3;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// halt freezes the divider clocks unless the free-run bit is set; an external bit clock still passes
	wire         run = !(emu_halt && !emu_ctl[`ACG_EMU_FREE_BIT]);

	// per-section clock path
	logic [1:0]  hc_tick;
	logic [1:0]  hc_level;
	logic [1:0]  bc_tick_int;
	logic [1:0]  bc_level_int;
	logic [1:0]  bit_rise;
	logic [1:0]  bit_level;
	logic [1:0]  fs_int;
	logic [1:0]  fs_level;
	logic [1:0]  clk_fail;
	logic [1:0]  ser_clk;
	logic [1:0]  ser_fs;
	logic [1:0]  fs_out;
	logic [1:0]  hc_out;
	logic [1:0]  bc_out;
	logic [1:0]  fs_oe;
	logic [1:0]  hc_oe;
	logic [1:0]  bc_oe;

	for (genvar s = 0; s < 2; s++) begin : g_sec
		localparam int PB = 1 + 3 * s;
		logic [7:0]             fcnt;
		logic [`ACG_CK_LIM_W:0] gap;
		wire  hc_int  = hc_ctl[s][`ACG_HC_INT_BIT];
		wire  bc_int  = bc_ctl[s][`ACG_BC_INT_BIT];
		wire  hc_src  = hc_int ? rise[0] : rise[PB + 1];
		wire  hc_srcl = hc_int ? sync2[0] : sync2[PB + 1];
		wire  ck_en   = ck_ctl[s][`ACG_CK_EN_BIT];
		wire  [`ACG_CK_LIM_W:0] limit = {1'b0, ck_ctl[s][`ACG_CK_LIM_W-1:0]};

		acg_divider #(.W(`ACG_HC_DIV_W)) u_high (
			.clock     (clock),
			.rstn      (rstn),
			.run       (run),
			.src_tick  (hc_src),
			.src_level (hc_srcl),
			.divisor   (hc_ctl[s][`ACG_HC_DIV_W-1:0]),
			.out_tick  (hc_tick[s]),
			.out_level (hc_level[s])
		);

		// second stage always fed by the first: the cascade of internal mode
		acg_divider #(.W(`ACG_BC_DIV_W)) u_bit (
			.clock     (clock),
			.rstn      (rstn),
			.run       (run),
			.src_tick  (hc_tick[s]),
			.src_level (hc_level[s]),
			.divisor   (bc_ctl[s][`ACG_BC_DIV_W-1:0]),
			.out_tick  (bc_tick_int[s]),
			.out_level (bc_level_int[s])
		);

		// external bit clock bypasses the divider entirely
		assign bit_rise[s]  = bc_int ? bc_tick_int[s] : rise[PB];
		assign bit_level[s] = bc_int ? bc_level_int[s] : sync2[PB];
		// frame sync comes from the same party as the bit clock
		assign fs_level[s]  = bc_int ? fs_int[s] : sync2[PB + 2];
		assign clk_fail[s]  = ck_en && !bc_int && run && (gap > limit);

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				fcnt      <= '0;
				fs_int[s] <= 1'b0;
				gap       <= '0;
			end else begin
				if (run && bit_rise[s]) begin
					fcnt      <= (fcnt == 8'(FRAME_BITS - 1)) ? 8'h00 : fcnt + 8'h01;
					fs_int[s] <= (fcnt == 8'(FRAME_BITS - 1));
				end
				gap <= (bit_rise[s] || !ck_en || clk_fail[s]) ? '0 : gap + 1'b1;
			end
		end

		// internal clocks run whatever the pin direction; oe alone gates the pins
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				ser_clk[s] <= 1'b0;
				ser_fs[s]  <= 1'b0;
				fs_out[s]  <= 1'b0;
				hc_out[s]  <= 1'b0;
				bc_out[s]  <= 1'b0;
				fs_oe[s]   <= 1'b0;
				hc_oe[s]   <= 1'b0;
				bc_oe[s]   <= 1'b0;
			end else begin
				ser_clk[s] <= bit_level[s];
				ser_fs[s]  <= fs_level[s];
				fs_out[s]  <= fs_int[s];
				hc_out[s]  <= hc_level[s];
				bc_out[s]  <= bc_level_int[s];
				fs_oe[s]   <= pdir[`ACG_PDIR_FS_BIT + `ACG_PDIR_STRIDE * s];
				hc_oe[s]   <= pdir[`ACG_PDIR_HC_BIT + `ACG_PDIR_STRIDE * s];
				bc_oe[s]   <= pdir[`ACG_PDIR_BC_BIT + `ACG_PDIR_STRIDE * s];
			end
		end
	end

	assign tx_frame_sync_pin_out = fs_out[0];
	assign tx_frame_sync_pin_oe  = fs_oe[0];
	assign tx_high_clock_pin_out = hc_out[0];
	assign tx_high_clock_pin_oe  = hc_oe[0];
	assign tx_bit_clock_pin_out  = bc_out[0];
	assign tx_bit_clock_pin_oe   = bc_oe[0];
	assign rx_frame_sync_pin_out = fs_out[1];
	assign rx_frame_sync_pin_oe  = fs_oe[1];
	assign rx_high_clock_pin_out = hc_out[1];
	assign rx_high_clock_pin_oe  = hc_oe[1];
	assign rx_bit_clock_pin_out  = bc_out[1];
	assign rx_bit_clock_pin_oe   = bc_oe[1];
	assign tx_serial_clock       = ser_clk[0];
	assign tx_frame_sync         = ser_fs[0];
	assign rx_serial_clock       = ser_clk[1];
	assign rx_frame_sync         = ser_fs[1];

	// write path: address and data may arrive in either order
	wire         wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire  [7:0]  wa      = 8'(aw_addr);
	wire  [31:0] wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire         sel_pdir   = wr_fire && wa == `ACG_ADDR_PDIR;
	wire         sel_emu    = wr_fire && wa == `ACG_ADDR_EMU;
	wire         sel_status = wr_fire && wa == `ACG_ADDR_STATUS;
	wire         sel_mask   = wr_fire && wa == `ACG_ADDR_MASK;
	wire  [1:0]  sel_hc = {wr_fire && wa == `ACG_ADDR_RX_HC, wr_fire && wa == `ACG_ADDR_TX_HC};
	wire  [1:0]  sel_bc = {wr_fire && wa == `ACG_ADDR_RX_BC, wr_fire && wa == `ACG_ADDR_TX_BC};
	wire  [1:0]  sel_ck = {wr_fire && wa == `ACG_ADDR_RX_CK, wr_fire && wa == `ACG_ADDR_TX_CK};
	wire         wr_hit = sel_pdir || sel_emu || sel_status || sel_mask
	                      || (|sel_hc) || (|sel_bc) || (|sel_ck);
	wire  [31:0] w1c    = sel_status ? (w_data & wmask) : `ACG_RST_ZERO;
	wire  [31:0] events = {30'h0, clk_fail};

	function automatic acg_word_t merge(acg_word_t old, acg_word_t m, acg_word_t d, acg_word_t k);
		merge = ((old & ~m) | (d & m)) & k;
	endfunction

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ACG_RESP_OKAY;
			aw_addr       <= '0;
			w_data        <= `ACG_RST_ZERO;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `ACG_RESP_OKAY : `ACG_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pdir    <= `ACG_RST_ZERO;
			emu_ctl <= `ACG_RST_ZERO;
			mask    <= `ACG_RST_ZERO;
			status  <= `ACG_RST_ZERO;
			for (int i = 0; i < 2; i++) begin
				hc_ctl[i] <= `ACG_RST_ZERO;
				bc_ctl[i] <= `ACG_RST_ZERO;
				ck_ctl[i] <= `ACG_RST_ZERO;
			end
		end else begin
			if (sel_pdir) pdir <= merge(pdir, wmask, w_data, `ACG_PDIR_MASK);
			if (sel_emu) emu_ctl <= merge(emu_ctl, wmask, w_data, `ACG_EMU_MASK);
			if (sel_mask) mask <= merge(mask, wmask, w_data, `ACG_IRQ_MASK);
			// a failure in the clearing cycle survives: set is ORed after the clear
			status <= ((status & ~w1c) | events) & `ACG_IRQ_MASK;
			for (int i = 0; i < 2; i++) begin
				if (sel_hc[i]) hc_ctl[i] <= merge(hc_ctl[i], wmask, w_data, `ACG_HC_MASK);
				if (sel_bc[i]) bc_ctl[i] <= merge(bc_ctl[i], wmask, w_data, `ACG_BC_MASK);
				if (sel_ck[i]) ck_ctl[i] <= merge(ck_ctl[i], wmask, w_data, `ACG_CK_MASK);
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) irq <= 1'b0;
		else irq <= |(status & mask);
	end

	// read path: one cycle from address to data
	wire  [7:0]  ra       = 8'(s_axi_araddr);
	wire  [31:0] state_rd = {25'h0, !run, fs_level, bit_level, hc_level};
	wire         ra_sec   = (ra >= `ACG_ADDR_RX_HC) && (ra <= `ACG_ADDR_RX_CK);
	wire  [7:0]  ra_off   = ra_sec ? ra - `ACG_SEC_STRIDE : ra;
	wire  [31:0] sec_hc   = ra_sec ? hc_ctl[1] : hc_ctl[0];
	wire  [31:0] sec_bc   = ra_sec ? bc_ctl[1] : bc_ctl[0];
	wire  [31:0] sec_ck   = ra_sec ? ck_ctl[1] : ck_ctl[0];
	wire         rd_sec   = ra <= `ACG_ADDR_RX_CK && ra != `ACG_ADDR_PDIR;
	wire  [31:0] rd_value =
		(ra == `ACG_ADDR_PDIR)             ? pdir    :
		(rd_sec && ra_off == `ACG_ADDR_TX_HC) ? sec_hc :
		(rd_sec && ra_off == `ACG_ADDR_TX_BC) ? sec_bc :
		(rd_sec && ra_off == `ACG_ADDR_TX_CK) ? sec_ck :
		(ra == `ACG_ADDR_EMU)              ? emu_ctl :
		(ra == `ACG_ADDR_STATUS)           ? status  :
		(ra == `ACG_ADDR_MASK)             ? mask    :
		(ra == `ACG_ADDR_STATE)            ? state_rd : `ACG_RST_ZERO;
	wire         rd_hit = (ra <= `ACG_ADDR_STATE) && (ra[1:0] == 2'h0);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `ACG_RST_ZERO;
			s_axi_rresp   <= `ACG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_value;
			s_axi_rresp   <= rd_hit ? `ACG_RESP_OKAY : `ACG_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	chk_input_undriven: assert property (@(posedge clock) disable iff (!rstn)
		!pdir[`ACG_PDIR_HC_BIT] |=> !tx_high_clock_pin_oe)
		else $error("tx high clock driven while set as input");
	chk_master_dirs: assert property (@(posedge clock) disable iff (!rstn)
		pdir == `ACG_PDIR_MASTER |=> tx_frame_sync_pin_oe && tx_high_clock_pin_oe
		&& tx_bit_clock_pin_oe && !rx_frame_sync_pin_oe && !rx_high_clock_pin_oe)
		else $error("master direction word mis-applied");
	chk_ext_high_dirs: assert property (@(posedge clock) disable iff (!rstn)
		pdir == `ACG_PDIR_EXT_HC |=> !tx_high_clock_pin_oe && tx_frame_sync_pin_oe
		&& tx_bit_clock_pin_oe)
		else $error("external high clock direction word mis-applied");
	chk_all_inputs: assert property (@(posedge clock) disable iff (!rstn)
		pdir == `ACG_PDIR_ALL_IN |=> !tx_frame_sync_pin_oe && !tx_bit_clock_pin_oe)
		else $error("transmit pins driven with all-input word");
	chk_bit_pin_follow: assert property (@(posedge clock) disable iff (!rstn)
		!bc_ctl[0][`ACG_BC_INT_BIT] |=> tx_serial_clock == $past(sync2[1]))
		else $error("external bit clock not followed");
	chk_div_one_pass: assert property (@(posedge clock) disable iff (!rstn)
		hc_ctl[0][`ACG_HC_INT_BIT] && hc_ctl[0][`ACG_HC_DIV_W-1:0] == 12'h000
		&& run && rise[0] |=> hc_tick[0])
		else $error("zero divisor does not pass aux clock");
	chk_bit_from_high: assert property (@(posedge clock) disable iff (!rstn)
		bc_tick_int[0] |-> $past(hc_tick[0]))
		else $error("bit divider stepped without high clock edge");
	chk_halt_freeze: assert property (@(posedge clock) disable iff (!rstn)
		!run ##1 !run |-> !hc_tick[0] && !hc_tick[1])
		else $error("clocks advance during halt");
	chk_fail_sticky: assert property (@(posedge clock) disable iff (!rstn)
		clk_fail[0] |=> status[0] ##1 (irq || !$past(mask[0])))
		else $error("clock failure not flagged");
endmodule

//--- dv/acg_converter_model.sv
// behavioural converter on the far side of the clock pins
`timescale 1ns/100ps
module acg_converter_model #(
	parameter int HALF_NS    = 500,
	parameter int FRAME_BITS = 4
) (
	input  wire logic [1:0] mode,
	output logic            high_clock,
	output logic            bit_clock,
	output logic            frame_sync
);
	int bit_count;
	initial begin
		high_clock = 1'b0;
		bit_clock = 1'b0;
		frame_sync = 1'b0;
		bit_count = 0;
	end
	// mode 1 makes a high clock, mode 2 a bit clock with its frame sync
	always begin
		#HALF_NS;
		if (mode == 2'd1) begin
			high_clock = ~high_clock;
		end else if (mode == 2'd2) begin
			bit_clock = ~bit_clock;
			if (!bit_clock) begin
				bit_count = (bit_count + 1) % FRAME_BITS;
				frame_sync = (bit_count == 0);
			end
		end
	end
	// a released line moves off its last level, so a stale value is never mistaken for a drive
	always @(mode) begin
		if (mode != 2'd1) begin
			high_clock = ~high_clock;
		end
		if (mode != 2'd2) begin
			bit_clock = ~bit_clock;
			frame_sync = ~frame_sync;
		end
	end
endmodule

//--- dv/audio_serial_clock_gen_tb.sv
// self-checking bench for the audio serial clock generator
`timescale 1ns/100ps
`include "acg_regs.svh"
module audio_serial_clock_gen_tb;
	import acg_pkg::*;
	typedef struct {
		logic        sec;
		logic [31:0] pdir;
		logic [31:0] hc;
		logic [31:0] bc;
		logic [1:0]  mode;
		logic [5:0]  oe;
		int          period;
	} acg_row_t;
	logic clock = 1'b0, rstn = 1'b0, aux_clock_in = 1'b0, emu_halt = 1'b0;
	logic [1:0] mode = 2'd0;
	wire  [5:0] pin_out, pin_oe;
	logic tx_serial_clock, tx_frame_sync, rx_serial_clock, rx_frame_sync, irq;
	logic p_hc, p_bc, p_fs;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	acg_resp_t s_axi_bresp, s_axi_rresp, resp;
	acg_word_t s_axi_rdata, rd;
	int miscompares = 0, total_checks = 0, n;
	// pin order rx fs, rx hc, rx bc, tx fs, tx hc, tx bc, as in the direction word
	wire [5:0] pin_wire = (pin_oe & pin_out) | (~pin_oe & {p_fs, p_hc, p_bc, p_fs, p_hc, p_bc});
	acg_row_t rows[6] = '{
		'{1'b0, 32'h1c00_0000, 32'h0000_8002, 32'h0000_0021, 2'd0, 6'b000111, 48},
		'{1'b0, 32'h1c00_0000, 32'h0000_8000, 32'h0000_0020, 2'd0, 6'b000111, 8},
		'{1'b0, 32'h1400_0000, 32'h0000_0001, 32'h0000_0022, 2'd1, 6'b000101, 60},
		'{1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_001f, 2'd2, 6'b000000, 10},
		'{1'b1, 32'he000_0000, 32'h0000_8001, 32'h0000_0021, 2'd0, 6'b111000, 32},
		'{1'b1, 32'h0000_0000, 32'h0000_8000, 32'h0000_0023, 2'd0, 6'b000000, 32}
	};
	always #50 clock = ~clock;
	// aux edges land on falling clock edges, midway between rising ones, so sampled periods come out exact
	always #400 aux_clock_in = ~aux_clock_in;
	acg_clock_gen #(.ADDR_W(8), .FRAME_BITS(4)) acg_clock_gen_inst (
		.clock(clock), .rstn(rstn), .aux_clock_in(aux_clock_in), .emu_halt(emu_halt),
		.tx_frame_sync_pin_in(pin_wire[2]), .tx_frame_sync_pin_out(pin_out[2]),
		.tx_frame_sync_pin_oe(pin_oe[2]), .tx_high_clock_pin_in(pin_wire[1]),
		.tx_high_clock_pin_out(pin_out[1]), .tx_high_clock_pin_oe(pin_oe[1]),
		.tx_bit_clock_pin_in(pin_wire[0]), .tx_bit_clock_pin_out(pin_out[0]),
		.tx_bit_clock_pin_oe(pin_oe[0]), .rx_frame_sync_pin_in(pin_wire[5]),
		.rx_frame_sync_pin_out(pin_out[5]), .rx_frame_sync_pin_oe(pin_oe[5]),
		.rx_high_clock_pin_in(pin_wire[4]), .rx_high_clock_pin_out(pin_out[4]),
		.rx_high_clock_pin_oe(pin_oe[4]), .rx_bit_clock_pin_in(pin_wire[3]),
		.rx_bit_clock_pin_out(pin_out[3]), .rx_bit_clock_pin_oe(pin_oe[3]),
		.tx_serial_clock(tx_serial_clock), .tx_frame_sync(tx_frame_sync),
		.rx_serial_clock(rx_serial_clock), .rx_frame_sync(rx_frame_sync), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);
	acg_converter_model #(.HALF_NS(500), .FRAME_BITS(4)) acg_converter_model_inst (
		.mode(mode), .high_clock(p_hc), .bit_clock(p_bc), .frame_sync(p_fs)
	);
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output acg_resp_t r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			// no local limit: only the watchdog may end a wait
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output acg_word_t d, output acg_resp_t r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	// cycles between the third and fourth rise, after the dividers have settled
	task automatic measure(input logic sec, output int per);
		logic prev, cur;
		int k, rises, last;
		rises = 0;
		last = 0;
		per = 0;
		prev = 1'b1;
		for (k = 0; k < 3000 && rises < 4; k++) begin
			@(posedge clock);
			cur = sec ? rx_serial_clock : tx_serial_clock;
			if (cur === 1'b1 && prev === 1'b0) begin
				rises++;
				per = k - last;
				last = k;
			end
			prev = cur;
		end
	endtask
	function automatic logic pick(input int sel);
		return (sel == 0) ? tx_serial_clock : (sel == 1) ? tx_frame_sync
			: (sel == 2) ? rx_frame_sync : pin_out[0];
	endfunction
	// window is a multiple of every steady period used, so counts come out exact
	task automatic count_rises(input int sel, output int c);
		logic prev, cur;
		c = 0;
		prev = pick(sel);
		repeat (128) begin
			@(posedge clock);
			cur = pick(sel);
			if (cur === 1'b1 && prev === 1'b0) c++;
			prev = cur;
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		check_word("oe_after_reset", 32'h0, {26'h0, pin_oe});
		axi_read(`ACG_ADDR_PDIR, rd, resp);
		check_word("pdir_reset", 32'h0, rd);
		foreach (rows[i]) begin
			mode <= rows[i].mode;
			axi_write(`ACG_ADDR_PDIR, rows[i].pdir, resp);
			axi_write(`ACG_ADDR_TX_HC + (rows[i].sec ? `ACG_SEC_STRIDE : 8'h00), rows[i].hc, resp);
			axi_write(`ACG_ADDR_TX_BC + (rows[i].sec ? `ACG_SEC_STRIDE : 8'h00), rows[i].bc, resp);
			measure(rows[i].sec, n);
			check_word("serial_period", rows[i].period, n);
			check_word("pin_oe", {26'h0, rows[i].oe}, {26'h0, pin_oe});
		end
		// halt freezes the dividers unless free-run is set
		axi_write(`ACG_ADDR_PDIR, 32'h1c00_0000, resp);
		axi_write(`ACG_ADDR_TX_HC, 32'h0000_8000, resp);
		axi_write(`ACG_ADDR_TX_BC, 32'h0000_0020, resp);
		emu_halt <= 1'b1;
		repeat (10) @(posedge clock);
		count_rises(0, n);
		check_word("halted_rises", 32'h0, n);
		axi_write(`ACG_ADDR_EMU, 32'h0000_0001, resp);
		count_rises(0, n);
		check_word("free_run", 32'h1, n > 10);
		count_rises(1, n);
		check_word("tx_frame_rate", 32'h4, n);
		count_rises(2, n);
		check_word("rx_frame_rate", 32'h1, n);
		count_rises(3, n);
		check_word("tx_bit_pin_rate", 32'h10, n);
		emu_halt <= 1'b0;
		// missing external bit clock raises the failure flag
		mode <= 2'd0;
		// pins as inputs, else the driven bit clock loops back and hides the failure
		axi_write(`ACG_ADDR_PDIR, 32'h0000_0000, resp);
		axi_write(`ACG_ADDR_TX_BC, 32'h0000_0000, resp);
		axi_write(`ACG_ADDR_TX_CK, 32'h0000_010a, resp);
		repeat (40) @(posedge clock);
		axi_read(`ACG_ADDR_STATUS, rd, resp);
		check_word("fail_status", 32'h1, rd);
		check_word("irq_masked", 32'h0, irq);
		axi_write(`ACG_ADDR_MASK, 32'h0000_0001, resp);
		repeat (3) @(posedge clock);
		check_word("irq_unmasked", 32'h1, irq);
		axi_write(`ACG_ADDR_TX_CK, 32'h0000_0000, resp);
		axi_write(`ACG_ADDR_STATUS, 32'h0000_0001, resp);
		repeat (3) @(posedge clock);
		check_word("irq_cleared", 32'h0, irq);
		axi_read(`ACG_ADDR_STATUS, rd, resp);
		check_word("status_cleared", 32'h0, rd);
		// reserved bits dropped, unmapped place refused
		axi_write(`ACG_ADDR_PDIR, 32'hffff_ffff, resp);
		axi_read(`ACG_ADDR_PDIR, rd, resp);
		check_word("pdir_reserved", `ACG_PDIR_MASK, rd);
		axi_write(8'h40, 32'h1234_5678, resp);
		check_word("unmapped_wresp", `ACG_RESP_SLVERR, resp);
		axi_read(8'h40, rd, resp);
		check_word("unmapped_rresp", `ACG_RESP_SLVERR, resp);
		check_word("unmapped_rdata", 32'h0, rd);
		test_done();
	end
endmodule
